// *** hw/mds_regs.svh ***
// register map, field positions and widths of the per-axis driver status word
`ifndef MDS_REGS_SVH
`define MDS_REGS_SVH

`define MDS_ADDR_W          7
`define MDS_ADDR_AXIS1      7'h6F
`define MDS_ADDR_AXIS2      7'h7F
`define MDS_BIT_STANDSTILL  31
`define MDS_BIT_OPEN_B      30
`define MDS_BIT_OPEN_A      29
`define MDS_BIT_SHORT_B     28
`define MDS_BIT_SHORT_A     27
`define MDS_BIT_PREWARN     26
`define MDS_BIT_SHUTDOWN    25
`define MDS_BIT_STALL       24
`define MDS_CS_LSB          16
`define MDS_CS_W            5
`define MDS_SG_W            10
`define MDS_CHOPPER_OFF_TIME_W          4
`define MDS_PIN_W           11
`define MDS_PIN_PREWARN     8
`define MDS_PIN_LIMIT       9
`define MDS_PIN_ENN         10
`define MDS_STATUS_RESET    32'h0000_0000

`endif

// *** hw/mds_pkg.sv ***
// types for the driver status flag bank
package mds_pkg;
  typedef struct packed {
    logic [10:0]      sync1;
    logic [10:0]      sync2;
    logic [1:0][1:0]  short_r;
    logic             ot_r;
    logic [1:0]       drv_en;
    logic [1:0][31:0] status;
    logic [31:0]      rdata;
    logic             rvalid;
  } mds_state_t;
endpackage

// *** hw/mds_status_flags.sv ***
// per-axis driver status words with shared thermal and latched short-to-ground protection
//
// How it works
// - two read-only status words, axis one at 0x6F, axis two at 0x7F
// - bit 31 shows standstill of the axis in every operation mode
// - bits 30 and 29 show open load on phase B and phase A
// - open load is informative only; driver enable ignores it
// - bits 28 and 27 show short to ground; a short disables that axis driver
// - short flags stay latched until off time is zero or enable-not is high
// - bit 26 shows temperature above the pre-warning threshold
// - one pre-warning condition is shown identically in both words
// - bit 25 shows shutdown; both drivers off until pre-warning also clears
// - one shutdown condition is shown identically in both words
// - bit 24 shows stall: load result zero or load-dependent-speed stall
// - bits 20 to 16 show the actual adaptive current scaling
// - stall detection compares the load result against zero
`timescale 1ns/1ps
`include "mds_regs.svh"

module mds_status_flags (
  input  wire logic                          clock_in,
  input  wire logic                          sys_rst_in,
  input  wire logic [`MDS_ADDR_W-1:0]        reg_addr_in,
  input  wire logic                          reg_rd_in,
  output logic      [31:0]                   reg_rdata_out,
  output logic                               reg_rvalid_out,
  input  wire logic [1:0]                    standstill_in,
  input  wire logic [1:0]                    open_load_a_in,
  input  wire logic [1:0]                    open_load_b_in,
  input  wire logic [1:0]                    short_ground_phase_a_in,
  input  wire logic [1:0]                    short_ground_phase_b_in,
  input  wire logic                          temp_prewarn_in,
  input  wire logic                          temp_limit_in,
  input  wire logic                          enable_not_input_in,
  input  wire logic [1:0]                    speed_mode_stall_in,
  input  wire logic [2*`MDS_SG_W-1:0]        load_measure_result_in,
  input  wire logic [2*`MDS_CS_W-1:0]        cs_actual_in,
  input  wire logic [2*`MDS_CHOPPER_OFF_TIME_W-1:0]      chopper_off_time_in,
  output logic      [1:0]                    driver_enable_out
);

  mds_pkg::mds_state_t st_r;
  mds_pkg::mds_state_t st_nxt;

  logic [`MDS_PIN_W-1:0] pins;
  logic [1:0]            off_w;
  logic [1:0]            stall_w;

  ////////////////////////////////////////////////////////////////////////////////
  // comparator and enable pins are asynchronous, so they pass two flops first

  always_comb begin
    pins = {enable_not_input_in, temp_limit_in, temp_prewarn_in,
            short_ground_phase_b_in[1], short_ground_phase_a_in[1],
            open_load_b_in[1], open_load_a_in[1],
            short_ground_phase_b_in[0], short_ground_phase_a_in[0],
            open_load_b_in[0], open_load_a_in[0]};
  end

  always_comb begin
    for (int a = 0; a < 2; a++) begin
      off_w[a]   = st_r.sync2[`MDS_PIN_ENN] ||
                   (chopper_off_time_in[a*`MDS_CHOPPER_OFF_TIME_W +: `MDS_CHOPPER_OFF_TIME_W] == 4'h0);
      stall_w[a] = (load_measure_result_in[a*`MDS_SG_W +: `MDS_SG_W] == 10'h000) ||
                   speed_mode_stall_in[a];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    st_nxt       = st_r;
    st_nxt.sync1 = pins;
    st_nxt.sync2 = st_r.sync1;
    // shutdown holds until the die has cooled below pre-warning as well
    if (st_r.sync2[`MDS_PIN_LIMIT]) begin
      st_nxt.ot_r = 1'b1;
    end else if (!st_r.sync2[`MDS_PIN_PREWARN]) begin
      st_nxt.ot_r = 1'b0;
    end
    for (int a = 0; a < 2; a++) begin
      for (int p = 0; p < 2; p++) begin
        // a short seen in the clearing cycle wins, so no event is lost
        if (st_r.sync2[a*4 + 2 + p]) begin
          st_nxt.short_r[a][p] = 1'b1;
        end else if (off_w[a]) begin
          st_nxt.short_r[a][p] = 1'b0;
        end
      end
      // open load is left out of the enable on purpose
      st_nxt.drv_en[a] = !off_w[a] && !(|st_nxt.short_r[a]) && !st_nxt.ot_r;
      st_nxt.status[a] = {standstill_in[a],
                          st_r.sync2[a*4 + 1], st_r.sync2[a*4],
                          st_nxt.short_r[a][1], st_nxt.short_r[a][0],
                          st_r.sync2[`MDS_PIN_PREWARN],
                          st_nxt.ot_r,
                          stall_w[a],
                          3'h0,
                          cs_actual_in[a*`MDS_CS_W +: `MDS_CS_W],
                          16'h0000};
    end
    // reads only select a word; nothing is cleared by them
    st_nxt.rvalid = reg_rd_in;
    if (!reg_rd_in) begin
      st_nxt.rdata = st_r.rdata;
    end else if (reg_addr_in == `MDS_ADDR_AXIS1) begin
      st_nxt.rdata = st_r.status[0];
    end else if (reg_addr_in == `MDS_ADDR_AXIS2) begin
      st_nxt.rdata = st_r.status[1];
    end else begin
      st_nxt.rdata = 32'h0000_0000;
    end
  end

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  always_comb begin
    reg_rdata_out     = st_r.rdata;
    reg_rvalid_out    = st_r.rvalid;
    driver_enable_out = st_r.drv_en;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (sys_rst_in);

  sequence rd_sq(logic [6:0] adr);
    reg_rd_in && reg_addr_in == adr;
  endsequence

  // three samples in a row carry a pin through both sync flops into the state
  sequence pin_high3_sq(logic pin);
    !sys_rst_in && pin ##1 pin ##1 pin;
  endsequence

  // the same for a pin that has gone quiet
  sequence pin_low3_sq(logic pin);
    !sys_rst_in && !pin ##1 !pin ##1 !pin;
  endsequence

  // a read strobe at an address outside the two status words
  sequence rd_unmapped_sq;
    reg_rd_in && reg_addr_in != `MDS_ADDR_AXIS1 && reg_addr_in != `MDS_ADDR_AXIS2;
  endsequence

  axis1_read_a: assert property (rd_sq(`MDS_ADDR_AXIS1) |=> reg_rvalid_out &&
                                 reg_rdata_out == $past(st_r.status[0]))
    else $error("axis one read returned wrong word");
  axis2_read_a: assert property (rd_sq(`MDS_ADDR_AXIS2) |=> reg_rvalid_out &&
                                 reg_rdata_out == $past(st_r.status[1]))
    else $error("axis two read returned wrong word");
  prewarn_share_a: assert property (st_r.status[0][`MDS_BIT_PREWARN] ==
                                    st_r.status[1][`MDS_BIT_PREWARN])
    else $error("pre-warning differs between axes");
  shutdown_share_a: assert property (st_r.status[0][`MDS_BIT_SHUTDOWN] ==
                                     st_r.status[1][`MDS_BIT_SHUTDOWN])
    else $error("shutdown differs between axes");
  prewarn_path_a: assert property (pin_high3_sq(temp_prewarn_in)
                                   |=> st_r.status[0][`MDS_BIT_PREWARN])
    else $error("pre-warning not shown three cycles after pin");
  shutdown_cool_a: assert property (st_r.ot_r && st_r.sync2[`MDS_PIN_PREWARN]
                                    |=> st_r.ot_r && driver_enable_out == 2'b00)
    else $error("shutdown released before cooling");

  ////////////////////////////////////////////////////////////////////////////////
  // thermal, enable-not, read port and per-axis status field checks

  // a limit held long enough to pass the sync flops must stop both stages
  limit_sets_ot_a: assert property (pin_high3_sq(temp_limit_in) |=>
                                    st_r.ot_r && driver_enable_out == 2'b00)
    else $error("limit did not shut both drivers down");

  // shutdown ends once both thermal comparators are quiet
  cool_release_a: assert property (st_r.ot_r && !st_r.sync2[`MDS_PIN_LIMIT] &&
                                   !st_r.sync2[`MDS_PIN_PREWARN] |=> !st_r.ot_r)
    else $error("shutdown not released after cooling");

  // a synced limit always sets the shutdown state
  limit_hold_a: assert property (st_r.sync2[`MDS_PIN_LIMIT] |=> st_r.ot_r)
    else $error("shutdown not set by limit");

  // enable-not switches both stages off after the sync delay
  enn_off_a: assert property (pin_high3_sq(enable_not_input_in) |=>
                              driver_enable_out == 2'b00)
    else $error("enable-not did not switch drivers off");

  // pre-warning falls with the pin, no latching
  prewarn_clear_a: assert property (pin_low3_sq(temp_prewarn_in) |=>
                                    !st_r.status[0][`MDS_BIT_PREWARN])
    else $error("pre-warning bit stuck");

  // valid pulses only for cycles with a strobe
  rvalid_idle_a: assert property (!reg_rd_in |=> !reg_rvalid_out)
    else $error("read valid without strobe");

  // read data is held between reads so a slow host still sees it
  rdata_hold_a: assert property (!reg_rd_in |=> $stable(reg_rdata_out))
    else $error("read data changed without a read");

  // unmapped addresses answer zero rather than a stale word
  unmapped_zero_a: assert property (rd_unmapped_sq |=>
                                    reg_rvalid_out && reg_rdata_out == 32'h0000_0000)
    else $error("unmapped read not zero");

  for (genvar a = 0; a < 2; a++) begin : g_chk
    standstill_live_a: assert property (!sys_rst_in |=> st_r.status[a][`MDS_BIT_STANDSTILL] ==
                                        $past(standstill_in[a]))
      else $error("standstill bit not live");
    stall_flag_a: assert property (!sys_rst_in |=>
                                   st_r.status[a][`MDS_BIT_STALL] == $past(stall_w[a]))
      else $error("stall bit wrong");
    cs_field_a: assert property (!sys_rst_in |=> st_r.status[a][20:16] ==
                                 $past(cs_actual_in[a*`MDS_CS_W +: `MDS_CS_W]))
      else $error("current scaling field wrong");
    reserved_zero_a: assert property (st_r.status[a][23:21] == 3'h0)
      else $error("reserved bits not zero");
    open_load_a: assert property (!sys_rst_in |=> st_r.status[a][30:29] ==
                                  $past(st_r.sync2[a*4 +: 2]))
      else $error("open load bits wrong");
    open_noact_a: assert property (!sys_rst_in |=> driver_enable_out[a] ==
                                   $past(!off_w[a] && !(|st_nxt.short_r[a]) && !st_nxt.ot_r))
      else $error("enable depends on something beyond shorts, off and shutdown");
    short_off_a: assert property (|st_r.short_r[a] |-> !driver_enable_out[a])
      else $error("driver enabled while short latched");
    short_hold_a: assert property (st_r.short_r[a][0] && !off_w[a] |=> st_r.short_r[a][0])
      else $error("short flag dropped while driver on");

    // each phase latches its own short and drops only its own axis
    short_a_set_a: assert property (pin_high3_sq(short_ground_phase_a_in[a]) |=>
                                    st_r.short_r[a][0] && !driver_enable_out[a])
      else $error("phase A short not latched");

    // phase B has its own latch bit
    short_b_set_a: assert property (pin_high3_sq(short_ground_phase_b_in[a]) |=>
                                    st_r.short_r[a][1] && !driver_enable_out[a])
      else $error("phase B short not latched");

    // switching the driver off clears the latch once the pins are quiet
    short_clear_a: assert property (off_w[a] && !st_r.sync2[a*4 + 2] &&
                                    !st_r.sync2[a*4 + 3] |=> st_r.short_r[a] == 2'b00)
      else $error("short latch not cleared by driver off");

    // off time zero or enable-not keeps the stage off
    off_disable_a: assert property (off_w[a] |=> !driver_enable_out[a])
      else $error("driver enabled while switched off");

    // shutdown blocks each stage in the same cycle it is shown
    ot_disable_a: assert property (st_r.ot_r |-> !driver_enable_out[a])
      else $error("driver enabled during shutdown");

    // load result and fullstep bits lie outside this word's scope
    low_zero_a: assert property (st_r.status[a][15:0] == 16'h0000)
      else $error("low status bits not zero");

    // a zero load result is a stall
    stall_zero_a: assert property (!sys_rst_in &&
                                   load_measure_result_in[a*`MDS_SG_W +: `MDS_SG_W] == 10'h000
                                   |=> st_r.status[a][`MDS_BIT_STALL])
      else $error("zero load result not shown as stall");

    // load-dependent speed mode reports its own stall
    stall_speed_a: assert property (!sys_rst_in && speed_mode_stall_in[a] |=>
                                    st_r.status[a][`MDS_BIT_STALL])
      else $error("speed mode stall not shown");

    // no stall source, no stall bit
    stall_clear_a: assert property (!sys_rst_in && !speed_mode_stall_in[a] &&
                                    load_measure_result_in[a*`MDS_SG_W +: `MDS_SG_W] != 10'h000
                                    |=> !st_r.status[a][`MDS_BIT_STALL])
      else $error("stall bit without a stall");

    // open load alone never takes a stage down
    open_enable_a: assert property (!sys_rst_in && st_r.sync2[a*4 +: 2] != 2'b00 &&
                                    !off_w[a] && !(|st_nxt.short_r[a]) && !st_nxt.ot_r
                                    |=> driver_enable_out[a])
      else $error("open load disabled the driver");

    // a read never clears a latched short
    read_keep_a: assert property (reg_rd_in && !off_w[a] |=>
                                  (st_r.short_r[a] & $past(st_r.short_r[a])) ==
                                  $past(st_r.short_r[a]))
      else $error("read cleared a short latch");
  end

endmodule // mds_status_flags

// *** testbench/mds_coil_model.sv ***
// coil model: reports phase A shorts and phase B open coils only while its power stage drives current
`timescale 1ns/1ps
module mds_coil_model (
  input  wire logic       clock_in,
  input  wire logic [1:0] driver_enable_in,
  input  wire logic [1:0] short_a_cmd_in,
  input  wire logic [1:0] open_b_cmd_in,
  output logic      [1:0] short_ground_phase_a_out,
  output logic      [1:0] open_load_b_out
);
  // a disabled stage carries no current, so the fault vanishes from the pin
  always_ff @(posedge clock_in) begin
    short_ground_phase_a_out <= short_a_cmd_in & driver_enable_in;
    open_load_b_out          <= open_b_cmd_in & driver_enable_in;
  end
endmodule // mds_coil_model

// *** testbench/mds_status_flags_tb.sv ***
// self-checking bench for the driver status flag bank
`timescale 1ns/1ps
`include "mds_regs.svh"
module mds_status_flags_tb;
  typedef struct packed {
    logic [1:0] ss, ms; logic [19:0] lr; logic [9:0] cs; logic [31:0] e0, e1;
  } mds_row_t;
  logic        clock_in, sys_rst_in, reg_rd_in, rv, pw, lim, enable_not_input;
  logic [6:0]  addr;
  logic [31:0] rd;
  logic [1:0]  ss, ms, oa, sb, sa_cmd, ob_cmd, sa, ob, en;
  logic [19:0] lr;
  logic [9:0]  cs;
  logic [7:0]  chopper_off_time;
  int          mismatches, n_compared, cyc;
  mds_row_t    rows [4] = '{
    '{2'b01, 2'b00, 20'h00400, 10'h3E0, 32'h8100_0000, 32'h001F_0000},
    '{2'b10, 2'b10, 20'hFFC01, 10'h015, 32'h0015_0000, 32'h8100_0000},
    '{2'b00, 2'b01, 20'h00200, 10'h030, 32'h0110_0000, 32'h0101_0000},
    '{2'b00, 2'b00, 20'hFFFFF, 10'h000, 32'h0, 32'h0}};
  mds_status_flags mds_status_flags_i (.clock_in(clock_in), .sys_rst_in(sys_rst_in),
    .reg_addr_in(addr), .reg_rd_in(reg_rd_in), .reg_rdata_out(rd), .reg_rvalid_out(rv),
    .standstill_in(ss), .open_load_a_in(oa), .open_load_b_in(ob),
    .short_ground_phase_a_in(sa), .short_ground_phase_b_in(sb), .temp_prewarn_in(pw),
    .temp_limit_in(lim), .enable_not_input_in(enable_not_input), .speed_mode_stall_in(ms),
    .load_measure_result_in(lr), .cs_actual_in(cs), .chopper_off_time_in(chopper_off_time),
    .driver_enable_out(en));
  mds_coil_model mds_coil_model_i (.clock_in(clock_in), .driver_enable_in(en),
    .short_a_cmd_in(sa_cmd), .open_b_cmd_in(ob_cmd), .short_ground_phase_a_out(sa),
    .open_load_b_out(ob));
  initial begin
    clock_in = 1'b0;
    forever #20 clock_in = ~clock_in;
  end
  task automatic report_and_stop;
    if (mismatches == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic rd_chk(input logic [6:0] a, input logic [31:0] e);
    addr = a;
    reg_rd_in = 1'b1;
    @(negedge clock_in);
    check({31'h0, rv}, 32'h1);
    check(rd, e);
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(negedge clock_in);
  endtask
  // hang guard: the whole sequence needs well under 300 cycles
  always @(posedge clock_in) begin
    cyc++;
    if (cyc == 2000) begin
      mismatches++;
      report_and_stop();
    end
  end
  initial begin
    {sys_rst_in, reg_rd_in, pw, lim, enable_not_input} = 5'h10;
    {addr, ss, ms, oa, sb, sa_cmd, ob_cmd, cs} = '0;
    lr = 20'hFFFFF;
    chopper_off_time = 8'h33;
    wait_n(5);
    check({30'h0, en}, 32'h0);
    sys_rst_in = 1'b0;
    for (int i = 0; i < 4; i++) begin
      {ss, ms, lr, cs} = {rows[i].ss, rows[i].ms, rows[i].lr, rows[i].cs};
      wait_n(1);
      rd_chk(`MDS_ADDR_AXIS1, rows[i].e0);
      rd_chk(`MDS_ADDR_AXIS2, rows[i].e1);
    end
    rd_chk(7'h00, 32'h0);
    sa_cmd = 2'b01;
    wait_n(5);
    sa_cmd = 2'b00;
    check({30'h0, en}, 32'h2);
    rd_chk(`MDS_ADDR_AXIS1, 32'h0800_0000);
    rd_chk(`MDS_ADDR_AXIS1, 32'h0800_0000);
    chopper_off_time[3:0] = 4'h0;
    wait_n(2);
    rd_chk(`MDS_ADDR_AXIS1, 32'h0);
    chopper_off_time[3:0] = 4'h3;
    sb = 2'b10;
    wait_n(4);
    sb = 2'b00;
    rd_chk(`MDS_ADDR_AXIS2, 32'h1000_0000);
    enable_not_input = 1'b1;
    wait_n(4);
    check({30'h0, en}, 32'h0);
    rd_chk(`MDS_ADDR_AXIS2, 32'h0);
    enable_not_input = 1'b0;
    {oa, ob_cmd} = 4'h6;
    wait_n(6);
    rd_chk(`MDS_ADDR_AXIS1, 32'h2000_0000);
    rd_chk(`MDS_ADDR_AXIS2, 32'h4000_0000);
    check({30'h0, en}, 32'h3);
    {oa, ob_cmd, pw} = 5'h01;
    wait_n(4);
    rd_chk(`MDS_ADDR_AXIS1, 32'h0400_0000);
    rd_chk(`MDS_ADDR_AXIS2, 32'h0400_0000);
    lim = 1'b1;
    wait_n(4);
    lim = 1'b0;
    check({30'h0, en}, 32'h0);
    rd_chk(`MDS_ADDR_AXIS2, 32'h0600_0000);
    wait_n(3);
    rd_chk(`MDS_ADDR_AXIS1, 32'h0600_0000);
    pw = 1'b0;
    wait_n(4);
    rd_chk(`MDS_ADDR_AXIS1, 32'h0);
    check({30'h0, en}, 32'h3);
    sb = 2'b01;
    wait_n(4);
    sys_rst_in = 1'b1;
    sb = 2'b00;
    wait_n(2);
    check({30'h0, en}, 32'h0);
    sys_rst_in = 1'b0;
    rd_chk(`MDS_ADDR_AXIS1, 32'h0);
    check({30'h0, en}, 32'h3);
    report_and_stop();
  end
endmodule // mds_status_flags_tb
